/* File: rtl/pmc_pkg.sv */
// Purpose: Shared constants and carriers for the port merge configuration.
// Assumes: Four ports in two even/odd pairs, four lanes per port.
// Notes: Port index 0..3 stands for port numbers 0, 1, 6, 7.
package pmc_pkg;
	localparam int PMC_NUM_PORTS = 4;
	localparam int PMC_NUM_PAIRS = 2;
	localparam int PMC_LANES_PER_PORT = 4;
	localparam int PMC_NUM_LANES = 16;
	localparam int PMC_UPSTREAM_IDX = 0;
	localparam logic [4:0] PMC_DEV_NUM [0:3] = '{5'h00, 5'h01, 5'h06, 5'h07};
	localparam logic [5:0] PMC_LINK_WIDTH_X4 = 6'h04;
	localparam logic [5:0] PMC_LINK_WIDTH_X8 = 6'h08;
	localparam logic [1:0] PMC_MERGE_RESET = 2'h0;
	localparam logic [2:0] PMC_MERGED_LANE_OFS = 3'h4;
	localparam logic [31:0] PMC_BLOCKED_RDATA = 32'h0000_0000;

	typedef logic [1:0] pmc_port_idx_t;
	typedef logic [2:0] pmc_lane_idx_t;

	// Sideband outputs a port drives towards its pins
	typedef struct packed {
		logic attn_led;
		logic pwr_led;
		logic pwr_en;
		logic link_up;
		logic link_active;
		logic port_reset;
	} pmc_port_out_t;

	// Sideband inputs a port takes from its pins
	typedef struct packed {
		logic attn_button;
		logic presence;
		logic mrl_sensor;
		logic pwr_fault;
	} pmc_port_in_t;

	typedef struct packed {
		logic valid;
		logic is_write;
		logic [4:0] dev;
	} pmc_cfg_req_t;

	typedef struct packed {
		logic valid;
		logic forward;
		logic unsupported;
		logic [4:0] dev;
	} pmc_cfg_resp_t;

	typedef struct packed {
		logic valid;
		logic is_write;
		pmc_port_idx_t port;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pmc_smb_req_t;
endpackage

/* File: rtl/pmc_strap_latch.sv */
// Purpose: Catch the pair join straps once after fundamental reset release.
// Assumes: rstn is the fundamental reset; straps are synchronous to clk.
// Notes: After capture the straps are never looked at again.
`timescale 1ns/1ps
`default_nettype none
module pmc_strap_latch
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pair_low_join_strap,
	input wire logic pair_high_join_strap,
	output logic [PMC_NUM_PAIRS-1:0] merge,
	output logic locked
);
	typedef enum logic {PMC_ST_CAPTURE, PMC_ST_LOCKED} pmc_latch_state_t;

	pmc_latch_state_t state_reg, state_next;
	logic [PMC_NUM_PAIRS-1:0] merge_reg, merge_next;

	always_comb begin
		state_next = state_reg;
		merge_next = merge_reg;
		unique case (state_reg)
			PMC_ST_CAPTURE: begin
				// First edge after release: the only moment straps count
				merge_next = {pair_high_join_strap, pair_low_join_strap};
				state_next = PMC_ST_LOCKED;
			end
			PMC_ST_LOCKED: begin
				merge_next = merge_reg;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= PMC_ST_CAPTURE;
			merge_reg <= PMC_MERGE_RESET;
		end else begin
			state_reg <= state_next;
			merge_reg <= merge_next;
		end
	end

	assign merge = merge_reg;
	assign locked = (state_reg == PMC_ST_LOCKED);
endmodule // pmc_strap_latch
`default_nettype wire

/* File: rtl/pmc_lane_map.sv */
// Purpose: Assign each physical lane to an owning port and a logical lane.
// Assumes: Merge settings are stable once locked.
// Notes: Lanes 4*p..4*p+3 belong to port index p when unmerged.
`timescale 1ns/1ps
`default_nettype none
module pmc_lane_map
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [PMC_NUM_PAIRS-1:0] merge,
	output pmc_port_idx_t [PMC_NUM_LANES-1:0] lane_owner,
	output pmc_lane_idx_t [PMC_NUM_LANES-1:0] lane_index
);
	pmc_port_idx_t [PMC_NUM_LANES-1:0] owner_reg, owner_next;
	pmc_lane_idx_t [PMC_NUM_LANES-1:0] index_reg, index_next;

	genvar l;
	generate
		for (l = 0; l < PMC_NUM_LANES; l++) begin : g_lane
			localparam pmc_port_idx_t PORT = pmc_port_idx_t'(l / PMC_LANES_PER_PORT);
			localparam pmc_lane_idx_t LOCAL = pmc_lane_idx_t'(l % PMC_LANES_PER_PORT);
			always_comb begin
				owner_next[l] = PORT;
				index_next[l] = LOCAL;
				if (PORT[0] && merge[PORT[1]]) begin
					// Odd port lanes extend the even port as lanes 4..7
					owner_next[l] = {PORT[1], 1'b0};
					index_next[l] = LOCAL + PMC_MERGED_LANE_OFS;
				end
			end
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					owner_reg[l] <= PORT;
					index_reg[l] <= LOCAL;
				end else begin
					owner_reg[l] <= owner_next[l];
					index_reg[l] <= index_next[l];
				end
			end
		end
	endgenerate

	assign lane_owner = owner_reg;
	assign lane_index = index_reg;
endmodule // pmc_lane_map
`default_nettype wire

/* File: rtl/pmc_port_merge.sv */
// Purpose: Static port merge configuration of a four port, sixteen lane switch.
// Assumes: rstn is the fundamental reset; all inputs synchronous to clk.
// Notes: Port enables and sideband pins stay quiet until the straps are locked.
`timescale 1ns/1ps
`default_nettype none
module pmc_port_merge
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pair_low_join_strap,
	input wire logic pair_high_join_strap,
	input wire pmc_port_out_t [PMC_NUM_PORTS-1:0] core_port_out,
	output pmc_port_out_t [PMC_NUM_PORTS-1:0] pin_port_out,
	input wire pmc_port_in_t [PMC_NUM_PORTS-1:0] pin_port_in,
	output pmc_port_in_t [PMC_NUM_PORTS-1:0] core_port_in,
	input wire pmc_cfg_req_t cfg_req,
	output pmc_cfg_resp_t cfg_resp,
	input wire pmc_smb_req_t smb_req,
	output pmc_smb_req_t smb_core_req,
	input wire logic [31:0] smb_core_rdata,
	output logic [31:0] smb_rdata,
	output logic smb_rdata_valid,
	output logic smb_blocked,
	output logic [PMC_NUM_PORTS-1:0] port_enable,
	output logic [PMC_NUM_PORTS-1:0] port_upstream,
	output logic [PMC_NUM_PORTS-1:0][5:0] max_link_width_field,
	output pmc_port_idx_t [PMC_NUM_LANES-1:0] lane_owner,
	output pmc_lane_idx_t [PMC_NUM_LANES-1:0] lane_index,
	output logic [PMC_NUM_PAIRS-1:0] pair_merged,
	output logic config_locked
);
	logic [PMC_NUM_PAIRS-1:0] merge;
	logic locked;

	// True when port index p is the odd half of a joined pair
	function automatic logic port_off(input logic [PMC_NUM_PAIRS-1:0] m,
		input pmc_port_idx_t p);
		port_off = p[0] && m[p[1]];
	endfunction

	// Map a virtual bus device number to a port index; hit is low on no match
	function automatic logic dev_to_port(input logic [4:0] dev,
		output pmc_port_idx_t p);
		dev_to_port = 1'b0;
		p = '0;
		for (int i = 0; i < PMC_NUM_PORTS; i++) begin
			if (dev == PMC_DEV_NUM[i]) begin
				dev_to_port = 1'b1;
				p = pmc_port_idx_t'(i);
			end
		end
	endfunction

	pmc_strap_latch u_strap (
		.clk(clk),
		.rstn(rstn),
		.pair_low_join_strap(pair_low_join_strap),
		.pair_high_join_strap(pair_high_join_strap),
		.merge(merge),
		.locked(locked)
	);

	pmc_lane_map u_lanes (
		.clk(clk),
		.rstn(rstn),
		.merge(merge),
		.lane_owner(lane_owner),
		.lane_index(lane_index)
	);

	// Port configuration state
	logic [PMC_NUM_PORTS-1:0] enable_reg, enable_next;
	logic [PMC_NUM_PORTS-1:0] upstream_reg, upstream_next;
	logic [PMC_NUM_PORTS-1:0][5:0] width_reg, width_next;

	always_comb begin
		for (int p = 0; p < PMC_NUM_PORTS; p++) begin
			upstream_next[p] = (p == PMC_UPSTREAM_IDX);
			enable_next[p] = locked && !port_off(merge, pmc_port_idx_t'(p));
			width_next[p] = PMC_LINK_WIDTH_X4;
			// Even port of a joined pair survives with eight lanes
			if (p % 2 == 0 && merge[p / 2])
				width_next[p] = PMC_LINK_WIDTH_X8;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_reg <= '0;
			upstream_reg <= '0;
			width_reg <= {PMC_NUM_PORTS{PMC_LINK_WIDTH_X4}};
		end else begin
			enable_reg <= enable_next;
			upstream_reg <= upstream_next;
			width_reg <= width_next;
		end
	end

	// Sideband gating; registered so pins never glitch from the core
	pmc_port_out_t [PMC_NUM_PORTS-1:0] pout_reg, pout_next;
	pmc_port_in_t [PMC_NUM_PORTS-1:0] pin_reg, pin_next;

	always_comb begin
		for (int p = 0; p < PMC_NUM_PORTS; p++) begin
			pout_next[p] = enable_next[p] ? core_port_out[p] : '0;
			pin_next[p] = enable_next[p] ? pin_port_in[p] : '0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pout_reg <= '0;
			pin_reg <= '0;
		end else begin
			pout_reg <= pout_next;
			pin_reg <= pin_next;
		end
	end

	// Configuration filter at the upstream port
	pmc_cfg_resp_t cfg_reg, cfg_next;

	always_comb begin
		pmc_port_idx_t tgt;
		logic hit;
		tgt = '0;
		hit = dev_to_port(cfg_req.dev, tgt);
		cfg_next = '0;
		cfg_next.valid = cfg_req.valid;
		cfg_next.dev = cfg_req.dev;
		if (cfg_req.valid) begin
			// A missing device answers as if it never existed
			if (hit && port_off(merge, tgt))
				cfg_next.unsupported = 1'b1;
			else
				cfg_next.forward = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cfg_reg <= '0;
		else
			cfg_reg <= cfg_next;
	end

	// SMBus register access filter
	pmc_smb_req_t smb_reg, smb_next;
	logic rd_pend_reg, rd_pend_next;
	logic blk_reg, blk_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	always_comb begin
		logic off;
		off = port_off(merge, smb_req.port);
		smb_next = smb_req;
		// Dropped writes never reach the register file
		smb_next.valid = smb_req.valid && !off;
		rd_pend_next = smb_req.valid && !smb_req.is_write;
		blk_next = smb_req.valid && off;
		rvalid_next = rd_pend_reg;
		rdata_next = rdata_reg;
		if (rd_pend_reg)
			rdata_next = blk_reg ? PMC_BLOCKED_RDATA : smb_core_rdata;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			smb_reg <= '0;
			rd_pend_reg <= 1'b0;
			blk_reg <= 1'b0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			smb_reg <= smb_next;
			rd_pend_reg <= rd_pend_next;
			blk_reg <= blk_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign pin_port_out = pout_reg;
	assign core_port_in = pin_reg;
	assign cfg_resp = cfg_reg;
	assign smb_core_req = smb_reg;
	assign smb_rdata = rdata_reg;
	assign smb_rdata_valid = rvalid_reg;
	assign smb_blocked = blk_reg;
	assign port_enable = enable_reg;
	assign port_upstream = upstream_reg;
	assign max_link_width_field = width_reg;
	assign pair_merged = merge;
	assign config_locked = locked;
endmodule // pmc_port_merge
`default_nettype wire

/* File: tb/pmc_port_merge_sva.sv */
// Purpose: Port merge checks on the top ports.
// Assumes: Bound into pmc_port_merge.
// Notes: ok_reg marks the settled configuration.
`timescale 1ns/1ps
`default_nettype none
module pmc_port_merge_chk
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pair_low_join_strap,
	input wire logic pair_high_join_strap,
	input wire pmc_port_out_t [PMC_NUM_PORTS-1:0] pin_port_out,
	input wire pmc_port_in_t [PMC_NUM_PORTS-1:0] core_port_in,
	input wire pmc_cfg_req_t cfg_req,
	input wire pmc_cfg_resp_t cfg_resp,
	input wire pmc_smb_req_t smb_req,
	input wire pmc_smb_req_t smb_core_req,
	input wire logic smb_blocked,
	input wire logic [PMC_NUM_PORTS-1:0] port_enable,
	input wire logic [PMC_NUM_PORTS-1:0] port_upstream,
	input wire logic [PMC_NUM_PORTS-1:0][5:0] max_link_width_field,
	input wire pmc_port_idx_t [PMC_NUM_LANES-1:0] lane_owner,
	input wire pmc_lane_idx_t [PMC_NUM_LANES-1:0] lane_index,
	input wire logic [PMC_NUM_PAIRS-1:0] pair_merged,
	input wire logic config_locked
);
	logic ok_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ok_reg <= 1'b0;
		end else begin
			ok_reg <= config_locked;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_cfg_dead;
		ok_reg && cfg_req.valid && pair_merged[0] && cfg_req.dev == 5'h01;
	endsequence
	sequence s_smb_dead;
		ok_reg && smb_req.valid && pair_merged[1] && smb_req.port == 2'h3;
	endsequence
	chk_upstream_fixed: assert property (ok_reg |-> port_upstream == 4'h1)
		else $error("upstream map wrong");
	chk_merge_hold: assert property (ok_reg |-> $stable(pair_merged))
		else $error("merge changed");
	chk_strap_catch: assert property ($rose(config_locked) |->
		pair_merged == {$past(pair_high_join_strap), $past(pair_low_join_strap)})
		else $error("straps not caught");
	chk_odd_disable: assert property (ok_reg |-> port_enable ==
		{~pair_merged[1], 1'b1, ~pair_merged[0], 1'b1})
		else $error("port enable wrong");
	chk_width_x8: assert property (ok_reg |-> max_link_width_field[2] ==
		(pair_merged[1] ? PMC_LINK_WIDTH_X8 : PMC_LINK_WIDTH_X4))
		else $error("link width wrong");
	chk_odd_quiet: assert property (ok_reg && pair_merged[0] |->
		pin_port_out[1] == '0)
		else $error("odd port output live");
	chk_odd_deaf: assert property (ok_reg && pair_merged[1] |->
		core_port_in[3] == '0)
		else $error("odd port input live");
	chk_cfg_refuse: assert property (s_cfg_dead |=>
		cfg_resp.valid && cfg_resp.unsupported && !cfg_resp.forward)
		else $error("config not refused");
	chk_smb_refuse: assert property (s_smb_dead |=>
		smb_blocked && !smb_core_req.valid)
		else $error("smbus not blocked");
	chk_lane_join: assert property (ok_reg && pair_merged[0] |->
		lane_owner[7] == 2'h0 && lane_index[7] == 3'h7)
		else $error("lane join wrong");
endmodule // pmc_port_merge_chk
bind pmc_port_merge pmc_port_merge_chk chk_u (.clk, .rstn,
	.pair_low_join_strap, .pair_high_join_strap, .pin_port_out,
	.core_port_in, .cfg_req, .cfg_resp, .smb_req, .smb_core_req,
	.smb_blocked, .port_enable, .port_upstream, .max_link_width_field,
	.lane_owner, .lane_index, .pair_merged, .config_locked);
`default_nettype wire

/* File: tb/pmc_regfile_model.sv */
// Purpose: Register file behind the SMBus path.
// Assumes: Read data is used in the cycle the request is out.
// Notes: Idle data flips each cycle so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module pmc_regfile_model
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire pmc_smb_req_t req,
	output logic [31:0] rdata
);
	logic [31:0] mem_reg [0:15];
	logic [31:0] idle_reg;
	logic [3:0] idx;
	assign idx = {req.port, req.addr[1:0]};
	always_comb begin
		rdata = req.valid ? mem_reg[idx] : idle_reg;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_reg <= 32'h5a5a_5a5a;
		end else begin
			idle_reg <= ~idle_reg;
		end
	end
	always_ff @(posedge clk) begin
		if (req.valid && req.is_write) begin
			mem_reg[idx] <= req.wdata;
		end
	end
endmodule // pmc_regfile_model
`default_nettype wire

/* File: tb/test_port_merge_configuration.sv */
// Purpose: Runs every strap setting through map, sideband, config, SMBus.
// Assumes: Straps held until the lock test.
// Notes: Port index 0..3 is port 0, 1, 6, 7.
`timescale 1ns/1ps
`default_nettype none
module test_port_merge_configuration
	import pmc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn, pair_low_join_strap, pair_high_join_strap;
	pmc_port_out_t [PMC_NUM_PORTS-1:0] core_port_out, pin_port_out;
	pmc_port_in_t [PMC_NUM_PORTS-1:0] pin_port_in, core_port_in;
	pmc_cfg_req_t cfg_req;
	pmc_cfg_resp_t cfg_resp;
	pmc_smb_req_t smb_req, smb_core_req;
	logic [31:0] smb_core_rdata, smb_rdata;
	logic smb_rdata_valid, smb_blocked, config_locked;
	logic [PMC_NUM_PORTS-1:0] port_enable, port_upstream;
	logic [PMC_NUM_PORTS-1:0][5:0] max_link_width_field;
	pmc_port_idx_t [PMC_NUM_LANES-1:0] lane_owner;
	pmc_lane_idx_t [PMC_NUM_LANES-1:0] lane_index;
	logic [PMC_NUM_PAIRS-1:0] pair_merged;
	int n_fail, checks, cyc;
	pmc_port_merge dut_u (.clk, .rstn, .pair_low_join_strap,
		.pair_high_join_strap, .core_port_out, .pin_port_out, .pin_port_in,
		.core_port_in, .cfg_req, .cfg_resp, .smb_req, .smb_core_req,
		.smb_core_rdata, .smb_rdata, .smb_rdata_valid, .smb_blocked,
		.port_enable, .port_upstream, .max_link_width_field, .lane_owner,
		.lane_index, .pair_merged, .config_locked);
	pmc_regfile_model reg_u (.clk, .rstn, .req(smb_core_req),
		.rdata(smb_core_rdata));
	always #20 clk = ~clk;
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic do_reset(logic [1:0] m);
		@(posedge clk);
		rstn <= 1'b0;
		pair_low_join_strap <= m[0];
		pair_high_join_strap <= m[1];
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic t_map(logic [1:0] m);
		int j;
		cmp("merged", {30'h0, m}, {30'h0, pair_merged});
		cmp("upstream", 32'h1, {28'h0, port_upstream});
		cmp("enable", {28'h0, ~m[1], 1'b1, ~m[0], 1'b1},
			{28'h0, port_enable});
		for (int i = 0; i < 2; i++) begin
			cmp("width", m[i] ? 32'h8 : 32'h4,
				{26'h0, max_link_width_field[2*i]});
		end
		for (int l = 0; l < 16; l++) begin
			j = (l / 4) % 2 == 1 && m[l / 8];
			cmp("owner", l / 4 - j, {30'h0, lane_owner[l]});
			cmp("index", l % 4 + 4 * j, {29'h0, lane_index[l]});
		end
	endtask
	task automatic t_side(logic [1:0] m);
		logic [3:0] en;
		en = {~m[1], 1'b1, ~m[0], 1'b1};
		@(posedge clk);
		core_port_out <= '1;
		pin_port_in <= '1;
		repeat (2) @(posedge clk);
		#1;
		for (int p = 0; p < 4; p++) begin
			cmp("pin_out", en[p] ? 32'h3f : 0, {26'h0, pin_port_out[p]});
			cmp("core_in", en[p] ? 32'hf : 0, {28'h0, core_port_in[p]});
		end
		@(posedge clk);
		core_port_out <= '0;
		pin_port_in <= '0;
	endtask
	task automatic t_cfg(logic [1:0] m);
		logic dead;
		// Reads and writes to each of the four port device numbers; answer must echo dev
		for (int i = 0; i < 8; i++) begin
			dead = i[0] && m[i[1]];
			@(posedge clk);
			cfg_req <= {1'b1, i[2], PMC_DEV_NUM[i[1:0]]};
			@(posedge clk);
			cfg_req <= '0;
			#1;
			cmp("cfg", {24'h0, 1'b1, ~dead, dead, PMC_DEV_NUM[i[1:0]]},
				{24'h0, cfg_resp});
		end
		@(posedge clk);
		#1;
		cmp("cfg_idle", 32'h0, {31'h0, cfg_resp.valid});
	endtask
	task automatic smb_op(logic wr, int p, logic [31:0] v, logic dead);
		@(posedge clk);
		smb_req <= {1'b1, wr, p[1:0], 12'h010, v};
		@(posedge clk);
		smb_req <= '0;
		#1;
		cmp("blocked", {31'h0, dead}, {31'h0, smb_blocked});
		cmp("core_req", {31'h0, ~dead}, {31'h0, smb_core_req.valid});
		if (!dead) cmp("core_port", p, {30'h0, smb_core_req.port});
		@(posedge clk);
		#1;
		cmp("rvalid", {31'h0, ~wr}, {31'h0, smb_rdata_valid});
		if (!wr) cmp("rdata", dead ? PMC_BLOCKED_RDATA : v, smb_rdata);
	endtask
	task automatic t_smb(logic [1:0] m);
		for (int p = 0; p < 4; p++) begin
			smb_op(1'b1, p, 32'h1234_5670 + p, p[0] && m[p / 2]);
			smb_op(1'b0, p, 32'h1234_5670 + p, p[0] && m[p / 2]);
		end
	endtask
	task automatic t_lock(logic [1:0] m);
		@(posedge clk);
		pair_low_join_strap <= ~m[0];
		pair_high_join_strap <= ~m[1];
		repeat (4) @(posedge clk);
		#1;
		cmp("locked", {30'h0, m}, {30'h0, pair_merged});
	endtask
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Run needs about 260 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict;
		end
	end
	initial begin
		rstn = 0;
		pair_low_join_strap = 0;
		pair_high_join_strap = 0;
		core_port_out = '0;
		pin_port_in = '0;
		cfg_req = '0;
		smb_req = '0;
		for (int k = 0; k < 4; k++) begin
			do_reset(k[1:0]);
			t_map(k[1:0]);
			t_side(k[1:0]);
			t_cfg(k[1:0]);
			t_smb(k[1:0]);
			t_lock(k[1:0]);
		end
		print_verdict;
	end
endmodule // test_port_merge_configuration
`default_nettype wire
